// *** rab_pkg.sv ***
// Constants and carriers for the register access attribute bank
package rab_pkg;

    // Configuration functions
    localparam logic       RAB_FN_BRIDGE    = 1'b0;
    localparam logic       RAB_FN_IOC       = 1'b1;

    // Configuration offsets
    localparam logic [7:0] RAB_OFF_MEM_BASE = 8'h10;
    localparam logic [7:0] RAB_OFF_ALT_BASE = 8'h40;
    localparam logic [7:0] RAB_OFF_ATTR_A   = 8'h4c;
    localparam logic [7:0] RAB_OFF_ATTR_B   = 8'h50;

    // SMBus-only offsets
    localparam logic [7:0] RAB_SMB_OFF_SCRATCH = 8'h00;
    localparam logic [7:0] RAB_SMB_OFF_STATUS  = 8'h04;

    // Window bases: 4 KB aligned, low bits read as zero
    localparam logic [31:0] RAB_BASE_MASK   = 32'hffff_f000;
    localparam logic [31:0] RAB_BASE_RESET  = 32'h0000_0000;
    localparam int          RAB_WIN_LSB     = 12;

    // Byte lanes of attribute register A
    localparam int RAB_LANE_RW         = 0;
    localparam int RAB_LANE_STICKY_RW  = 1;
    localparam int RAB_LANE_W1C        = 2;
    localparam int RAB_LANE_STICKY_W1C = 3;
    // Byte lanes of attribute register B (lane 3 reserved)
    localparam int RAB_LANE_ONCE       = 0;
    localparam int RAB_LANE_STICKY_RO  = 1;
    localparam int RAB_LANE_RO         = 2;

    // Field defaults
    localparam logic [7:0]  RAB_BYTE_RESET  = 8'h00;
    localparam logic [31:0] RAB_WORD_RESET  = 32'h0000_0000;

    // Configuration port request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        func;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } rab_cfg_req_t;

    // SMBus port request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rab_smb_req_t;

    // Answer for either port
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } rab_rsp_t;

endpackage

// *** rab_register_bank.sv ***
// Register bank with read-only, clear, once and sticky bit attributes
module rab_register_bank
    import rab_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         reset,
    input  wire logic         power_good_reset,
    input  wire rab_cfg_req_t cfg_req,
    output rab_rsp_t          cfg_rsp,
    input  wire rab_smb_req_t smb_req,
    output rab_rsp_t          smb_rsp,
    input  wire logic [7:0]   hw_event,
    input  wire logic [7:0]   hw_sticky_event,
    input  wire logic [7:0]   hw_fault,
    input  wire logic [7:0]   hw_status,
    input  wire logic [7:0]   smb_status,
    input  wire logic         mem_valid,
    input  wire logic [31:0]  mem_addr,
    output logic [31:0]       ioc_mem_base,
    output logic [31:0]       ioc_alt_base,
    output logic [31:0]       hp_mem_base,
    output logic              ioc_window_hit,
    output logic              hp_window_hit,
    output logic [7:0]        rw_ctrl,
    output logic [7:0]        sticky_rw_ctrl
);

    logic [7:0] write_one_clear;
    logic [7:0] sticky_write_one_clear;
    logic [7:0] sticky_read_only;
    logic [7:0] ro_live;
    logic [7:0] write_once;
    logic       write_once_locked;
    logic [31:0] smb_scratch;
    logic       wr_br;
    logic       wr_ioc;
    logic       wr_a;
    logic       wr_b;
    logic [7:0] clr_a;
    logic [7:0] clr_s;

    // Byte-enabled merge limited to writable bits
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++)
        begin
            if (be[k])
            begin
                res[8*k +: 8] = (old[8*k +: 8] & ~mask[8*k +: 8])
                              | (wd[8*k +: 8] & mask[8*k +: 8]);
            end
        end
        return res;
    endfunction

    // Write decode per function and location
    assign wr_br  = cfg_req.valid && cfg_req.write
                    && cfg_req.func == RAB_FN_BRIDGE;
    assign wr_ioc = cfg_req.valid && cfg_req.write
                    && cfg_req.func == RAB_FN_IOC;
    assign wr_a   = wr_br && cfg_req.addr == RAB_OFF_ATTR_A;
    assign wr_b   = wr_br && cfg_req.addr == RAB_OFF_ATTR_B;
    assign clr_a  = (wr_a && cfg_req.be[RAB_LANE_W1C])
                    ? cfg_req.wdata[8*RAB_LANE_W1C +: 8] : RAB_BYTE_RESET;
    assign clr_s  = (wr_a && cfg_req.be[RAB_LANE_STICKY_W1C])
                    ? cfg_req.wdata[8*RAB_LANE_STICKY_W1C +: 8]
                    : RAB_BYTE_RESET;

    // Window bases, loaded with defaults by either reset
    always_ff @(posedge clock)
    begin
        if (reset || power_good_reset)
        begin
            ioc_mem_base <= RAB_BASE_RESET;
            ioc_alt_base <= RAB_BASE_RESET;
            hp_mem_base  <= RAB_BASE_RESET;
        end
        else
        begin
            if (wr_ioc && cfg_req.addr == RAB_OFF_MEM_BASE)
                ioc_mem_base <= merge(ioc_mem_base, cfg_req.wdata,
                                      cfg_req.be, RAB_BASE_MASK);
            if (wr_ioc && cfg_req.addr == RAB_OFF_ALT_BASE)
                ioc_alt_base <= merge(ioc_alt_base, cfg_req.wdata,
                                      cfg_req.be, RAB_BASE_MASK);
            if (wr_br && cfg_req.addr == RAB_OFF_MEM_BASE)
                hp_mem_base <= merge(hp_mem_base, cfg_req.wdata,
                                     cfg_req.be, RAB_BASE_MASK);
        end
    end

    // Plain read/write and write-one-clear fields
    always_ff @(posedge clock)
    begin
        if (reset || power_good_reset)
        begin
            rw_ctrl         <= RAB_BYTE_RESET;
            write_one_clear <= RAB_BYTE_RESET;
        end
        else
        begin
            if (wr_a && cfg_req.be[RAB_LANE_RW])
                rw_ctrl <= cfg_req.wdata[8*RAB_LANE_RW +: 8];
            // New event wins over a clear in the same cycle
            write_one_clear <= (write_one_clear & ~clr_a) | hw_event;
        end
    end

    // Live read-only copy, never written by software
    always_ff @(posedge clock)
    begin
        ro_live <= hw_status;
    end

    // Sticky fields: only power-good returns them to default
    always_ff @(posedge clock)
    begin
        if (power_good_reset)
        begin
            sticky_rw_ctrl         <= RAB_BYTE_RESET;
            sticky_write_one_clear <= RAB_BYTE_RESET;
            sticky_read_only       <= RAB_BYTE_RESET;
        end
        else
        begin
            if (wr_a && !reset && cfg_req.be[RAB_LANE_STICKY_RW])
                sticky_rw_ctrl <=
                    cfg_req.wdata[8*RAB_LANE_STICKY_RW +: 8];
            sticky_write_one_clear <= (sticky_write_one_clear
                & ~(reset ? RAB_BYTE_RESET : clr_s))
                | hw_sticky_event;
            sticky_read_only <= sticky_read_only | hw_fault;
        end
    end

    // Write-once field locks until power is cycled
    always_ff @(posedge clock)
    begin
        if (power_good_reset)
        begin
            write_once        <= RAB_BYTE_RESET;
            write_once_locked <= 1'b0;
        end
        else if (wr_b && !reset && !write_once_locked
                 && cfg_req.be[RAB_LANE_ONCE])
        begin
            write_once        <= cfg_req.wdata[8*RAB_LANE_ONCE +: 8];
            write_once_locked <= 1'b1;
        end
    end

    // Configuration read answer, one cycle after the request
    always_ff @(posedge clock)
    begin
        if (reset || power_good_reset)
        begin
            cfg_rsp <= '0;
        end
        else
        begin
            cfg_rsp.ack   <= cfg_req.valid;
            cfg_rsp.rdata <= RAB_WORD_RESET;
            if (cfg_req.valid && !cfg_req.write)
            begin
                unique case ({cfg_req.func, cfg_req.addr})
                    {RAB_FN_IOC, RAB_OFF_MEM_BASE}:
                        cfg_rsp.rdata <= ioc_mem_base;
                    {RAB_FN_IOC, RAB_OFF_ALT_BASE}:
                        cfg_rsp.rdata <= ioc_alt_base;
                    {RAB_FN_BRIDGE, RAB_OFF_MEM_BASE}:
                        cfg_rsp.rdata <= hp_mem_base;
                    {RAB_FN_BRIDGE, RAB_OFF_ATTR_A}:
                        cfg_rsp.rdata <= {sticky_write_one_clear,
                                          write_one_clear,
                                          sticky_rw_ctrl, rw_ctrl};
                    {RAB_FN_BRIDGE, RAB_OFF_ATTR_B}:
                        cfg_rsp.rdata <= {RAB_BYTE_RESET, ro_live,
                                          sticky_read_only,
                                          write_once};
                    default:
                        cfg_rsp.rdata <= RAB_WORD_RESET;
                endcase
            end
        end
    end

    // SMBus-only fields, absent from configuration space
    always_ff @(posedge clock)
    begin
        if (reset || power_good_reset)
        begin
            smb_scratch <= RAB_WORD_RESET;
            smb_rsp     <= '0;
        end
        else
        begin
            if (smb_req.valid && smb_req.write
                && smb_req.addr == RAB_SMB_OFF_SCRATCH)
                smb_scratch <= smb_req.wdata;
            smb_rsp.ack   <= smb_req.valid;
            smb_rsp.rdata <= RAB_WORD_RESET;
            if (smb_req.valid && !smb_req.write)
            begin
                if (smb_req.addr == RAB_SMB_OFF_SCRATCH)
                    smb_rsp.rdata <= smb_scratch;
                else if (smb_req.addr == RAB_SMB_OFF_STATUS)
                    smb_rsp.rdata <= {24'h00_0000, smb_status};
            end
        end
    end

    // Memory window decode against programmed bases
    always_ff @(posedge clock)
    begin
        if (reset || power_good_reset)
        begin
            ioc_window_hit <= 1'b0;
            hp_window_hit  <= 1'b0;
        end
        else
        begin
            ioc_window_hit <= mem_valid && (
                (ioc_mem_base != RAB_BASE_RESET && mem_addr[31:RAB_WIN_LSB]
                    == ioc_mem_base[31:RAB_WIN_LSB])
             || (ioc_alt_base != RAB_BASE_RESET && mem_addr[31:RAB_WIN_LSB]
                    == ioc_alt_base[31:RAB_WIN_LSB]));
            hp_window_hit <= mem_valid && hp_mem_base != RAB_BASE_RESET
                && mem_addr[31:RAB_WIN_LSB]
                   == hp_mem_base[31:RAB_WIN_LSB];
        end
    end

    // Checks on the attribute behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (power_good_reset);

    ro_copy_a: assert property (
        !$past(power_good_reset) |-> ro_live == $past(hw_status))
        else $error("read-only field differs from hardware status");
    sticky_ro_keep_a: assert property (
        reset |=> sticky_read_only
        == ($past(sticky_read_only) | $past(hw_fault)))
        else $error("sticky read-only lost value across reset");
    rw_store_a: assert property (
        wr_a && !reset && cfg_req.be[RAB_LANE_RW]
        |=> rw_ctrl == $past(cfg_req.wdata[7:0]))
        else $error("read/write field did not store write");
    w1c_clear_a: assert property (
        !reset && hw_event == 8'h00
        |=> (write_one_clear & $past(clr_a)) == 8'h00
        && (write_one_clear | $past(clr_a))
           == ($past(write_one_clear) | $past(clr_a)))
        else $error("write-one-clear field misbehaved");
    sticky_w1c_keep_a: assert property (
        reset |=> sticky_write_one_clear
        == ($past(sticky_write_one_clear) | $past(hw_sticky_event)))
        else $error("sticky clear field lost value across reset");
    once_lock_a: assert property (
        write_once_locked |=> write_once_locked && $stable(write_once))
        else $error("write-once field changed after lock");
    sticky_rw_keep_a: assert property (
        reset |=> $stable(sticky_rw_ctrl))
        else $error("sticky read/write changed during reset");
    rsvd_read_a: assert property (
        cfg_req.valid && !cfg_req.write
        && !reset && cfg_req.addr == 8'h00 |=> cfg_rsp.ack
        && cfg_rsp.rdata == 32'h0000_0000)
        else $error("reserved location read not zero");
    full_reset_a: assert property (
        reset |=> rw_ctrl == 8'h00
        && ioc_mem_base == 32'h0000_0000 && hp_mem_base == 32'h0000_0000)
        else $error("full reset did not load defaults");
    smb_only_a: assert property (
        !(smb_req.valid && smb_req.write)
        && !reset |=> $stable(smb_scratch))
        else $error("SMBus field changed without SMBus write");
    pg_default_a: assert property (
        @(posedge clock) disable iff (1'b0)
        power_good_reset |=> sticky_rw_ctrl == 8'h00
        && write_once_locked == 1'b0 && write_once == 8'h00
        && sticky_write_one_clear == 8'h00
        && sticky_read_only == 8'h00 && rw_ctrl == 8'h00)
        else $error("power-good reset left a non-default bit");

    once_lock_c: cover property (wr_b && !write_once_locked ##1 wr_b);
    w1c_clear_c: cover property (write_one_clear != 8'h00 ##1 clr_a != 8'h00);
    win_hit_c: cover property (ioc_window_hit ##1 hp_window_hit);

endmodule // rab_register_bank

// *** rab_host_model.sv ***
// Host model issuing configuration and SMBus requests
module rab_host_model
    import rab_pkg::*;
(
    input  wire logic         clock,
    output rab_cfg_req_t      cfg_req,
    input  wire rab_rsp_t     cfg_rsp,
    output rab_smb_req_t      smb_req,
    input  wire rab_rsp_t     smb_rsp
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [31:0] rd;
    logic        got;

    // Idle buses at time zero
    initial
    begin
        cfg_req = '0;
        smb_req = '0;
    end

    // One config request; released lines show the inverse pattern
    task automatic cfg(input logic wr, input logic fn, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] wd);
        @(posedge clock);
        #1;
        cfg_req = '{1'b1, wr, fn, a, be, wd};
        @(posedge clock);
        #1;
        got = cfg_rsp.ack;
        rd = cfg_rsp.rdata;
        cfg_req = '{1'b0, 1'b0, ~fn, ~a, ~be, ~wd};
    endtask

    // One SMBus request, same handshake
    task automatic smb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clock);
        #1;
        smb_req = '{1'b1, wr, a, wd};
        @(posedge clock);
        #1;
        got = smb_rsp.ack;
        rd = smb_rsp.rdata;
        smb_req = '{1'b0, 1'b0, ~a, ~wd};
    endtask

    // Read, merge only the owned field, write back
    task automatic rmw(input logic fn, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] v);
        cfg(1'b0, fn, a, 4'hf, 32'h0000_0000);
        cfg(1'b1, fn, a, 4'hf, (rd & ~m) | (v & m));
    endtask

endmodule // rab_host_model

// *** tb_rab_register_bank.sv ***
// Self-checking bench for the register access attribute bank
module tb_rab_register_bank
    import rab_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic        fn;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wd;
        logic [31:0] exp;
    } rab_row_t;

    logic         clock = 1'b0;
    logic         reset = 1'b1;
    logic         power_good_reset = 1'b1;
    logic [7:0]   hw_event = 8'h00;
    logic [7:0]   hw_sticky_event = 8'h00;
    logic [7:0]   hw_fault = 8'h00;
    logic [7:0]   hw_status = 8'h96;
    logic [7:0]   smb_status = 8'h5c;
    logic         mem_valid = 1'b0;
    logic [31:0]  mem_addr = 32'h0000_0000;
    rab_cfg_req_t cfg_req;
    rab_rsp_t     cfg_rsp;
    rab_smb_req_t smb_req;
    rab_rsp_t     smb_rsp;
    logic         ioc_window_hit;
    logic         hp_window_hit;
    logic [7:0]   rw_ctrl;
    logic [7:0]   sticky_rw_ctrl;
    logic [31:0]  ioc_mem_base;
    logic [31:0]  ioc_alt_base;
    logic [31:0]  hp_mem_base;
    int           mismatches = 0;
    int           n_tests = 0;
    // Write row then read back: func, offset, lanes, data, readback
    rab_row_t     rows [6] = '{
        '{1'b1, 8'h10, 4'hf, 32'h1234_5678, 32'h1234_5000},
        '{1'b1, 8'h40, 4'hf, 32'hffff_ffff, 32'hffff_f000},
        '{1'b0, 8'h10, 4'hf, 32'habcd_e123, 32'habcd_e000},
        '{1'b0, 8'h4c, 4'h3, 32'h0000_a55a, 32'h0000_a55a},
        '{1'b0, 8'h50, 4'hf, 32'h0000_ff3c, 32'h0096_003c},
        '{1'b0, 8'h50, 4'hf, 32'h0000_00c3, 32'h0096_003c}
    };

    always #20 clock = ~clock;

    rab_host_model host (.clock(clock), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
                         .smb_req(smb_req), .smb_rsp(smb_rsp));

    rab_register_bank uut (
        .clock(clock), .reset(reset), .power_good_reset(power_good_reset),
        .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .smb_req(smb_req), .smb_rsp(smb_rsp),
        .hw_event(hw_event), .hw_sticky_event(hw_sticky_event),
        .hw_fault(hw_fault), .hw_status(hw_status), .smb_status(smb_status),
        .mem_valid(mem_valid), .mem_addr(mem_addr),
        .ioc_mem_base(ioc_mem_base), .ioc_alt_base(ioc_alt_base),
        .hp_mem_base(hp_mem_base),
        .ioc_window_hit(ioc_window_hit), .hp_window_hit(hp_window_hit),
        .rw_ctrl(rw_ctrl), .sticky_rw_ctrl(sticky_rw_ctrl));

    // Compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        n_tests++;
        if (seen !== want)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // Config read that must be acknowledged with the given data
    task automatic rd_chk(input logic fn, input logic [7:0] a,
                          input logic [31:0] want);
        host.cfg(1'b0, fn, a, 4'hf, 32'h0000_0000);
        check({host.got, host.rd}, {1'b1, want});
    endtask

    // One-cycle pulse on the hardware set inputs
    task automatic pulse(input logic [7:0] ev, input logic [7:0] sev,
                         input logic [7:0] flt);
        @(posedge clock);
        #1;
        {hw_event, hw_sticky_event, hw_fault} = {ev, sev, flt};
        @(posedge clock);
        #1;
        {hw_event, hw_sticky_event, hw_fault} = 24'h00_0000;
    endtask

    // Two cycles of ordinary or power-good reset
    task automatic rst(input logic pg);
        @(posedge clock);
        #1;
        {power_good_reset, reset} = {pg, ~pg};
        repeat (2) @(posedge clock);
        #1;
        {power_good_reset, reset} = 2'b00;
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #200000;
        mismatches++;
        final_report();
    end

    initial
    begin
        repeat (4) @(posedge clock);
        #1;
        {power_good_reset, reset} = 2'b00;
        foreach (rows[i])
        begin
            host.cfg(1'b1, rows[i].fn, rows[i].addr, rows[i].be, rows[i].wd);
            check({host.got, host.rd}, 33'h1_0000_0000);
            rd_chk(rows[i].fn, rows[i].addr, rows[i].exp);
        end
        // Window base outputs follow the programmed registers
        check({1'b0, ioc_mem_base}, 33'h0_1234_5000);
        check({1'b0, ioc_alt_base}, 33'h0_ffff_f000);
        check({1'b0, hp_mem_base}, 33'h0_abcd_e000);
        // Window decode
        @(posedge clock);
        #1;
        mem_valid = 1'b1;
        mem_addr = 32'h1234_5fff;
        @(posedge clock);
        #1;
        check(33'({ioc_window_hit, hp_window_hit}), 33'h0_0000_0002);
        mem_addr = 32'habcd_e000;
        @(posedge clock);
        #1;
        check(33'({ioc_window_hit, hp_window_hit}), 33'h0_0000_0001);
        mem_valid = 1'b0;
        // Clear bits: set by hardware, write one clears, zero keeps
        pulse(8'h0f, 8'hf0, 8'h81);
        rd_chk(1'b0, 8'h4c, 32'hf00f_a55a);
        host.cfg(1'b1, 1'b0, 8'h4c, 4'hc, 32'h3003_0000);
        rd_chk(1'b0, 8'h4c, 32'hc00c_a55a);
        host.cfg(1'b1, 1'b0, 8'h50, 4'h2, 32'h0000_0000);
        rd_chk(1'b0, 8'h50, 32'h0096_813c);
        // Ordinary reset keeps sticky and write-once state
        rst(1'b0);
        rd_chk(1'b0, 8'h4c, 32'hc000_a500);
        check(33'({sticky_rw_ctrl, rw_ctrl}), 33'h0_0000_a500);
        rd_chk(1'b0, 8'h50, 32'h0096_813c);
        rd_chk(1'b1, 8'h10, 32'h0000_0000);
        check({1'b0, hp_mem_base}, 33'h0_0000_0000);
        // Power-good reset clears all but the live read-only byte and unlocks write-once
        rst(1'b1);
        rd_chk(1'b0, 8'h4c, 32'h0000_0000);
        rd_chk(1'b0, 8'h50, 32'h0096_0000);
        host.cfg(1'b1, 1'b0, 8'h50, 4'h1, 32'h0000_0011);
        rd_chk(1'b0, 8'h50, 32'h0096_0011);
        host.rmw(1'b0, 8'h4c, 32'h0000_ff00, 32'h0000_7700);
        rd_chk(1'b0, 8'h4c, 32'h0000_7700);
        // SMBus-only fields, invisible in config space
        host.smb(1'b1, 8'h00, 32'hdead_beef);
        host.smb(1'b0, 8'h00, 32'h0000_0000);
        check({host.got, host.rd}, 33'h1_dead_beef);
        host.smb(1'b0, 8'h04, 32'h0000_0000);
        check({host.got, host.rd}, 33'h1_0000_005c);
        rd_chk(1'b0, 8'h00, 32'h0000_0000);
        // Read-only byte tracks a changed hardware status
        hw_status = 8'h69;
        rd_chk(1'b0, 8'h50, 32'h0069_0011);
        final_report();
    end

endmodule // tb_rab_register_bank
